// *** adwd_params.svh ***
// constants for the converter window detector and its post-track timer
// assumes an 8-bit special function register bus on the system clock
`ifndef ADWD_PARAMS_SVH
`define ADWD_PARAMS_SVH

// ------------------------------------------------------------
// register map, page 0
// ------------------------------------------------------------
`define ADWD_PAGE 8'h00
`define ADWD_GTH_ADDR 8'hc4
`define ADWD_GTL_ADDR 8'hc3
`define ADWD_LTH_ADDR 8'hc6
`define ADWD_LTL_ADDR 8'hc5
`define ADWD_CTRL_ADDR 8'hc0
`define ADWD_TRACK_ADDR 8'hc1

// ------------------------------------------------------------
// reset values and fields
// ------------------------------------------------------------
`define ADWD_GT_RST 8'hff
`define ADWD_LT_RST 8'h00
`define ADWD_CTRL_RST 8'h00
`define ADWD_TRACK_RST 8'h00
`define ADWD_FLAG_BIT 3
`define ADWD_PTS_HI 1
`define ADWD_PTS_LO 0
`define ADWD_ZERO8 8'h00

// ------------------------------------------------------------
// post-track timing
// ------------------------------------------------------------
`define ADWD_SYS_CYCLES 5'h02
`define ADWD_SAR_BASE 5'h02
`define ADWD_CNT_ONE 5'h01
`define ADWD_CNT_ZERO 5'h00

`endif

// *** adwd_pkg.sv ***
// types shared by the window detector and its post-track timer
// assumes nothing beyond the constants header
package adwd_pkg;
   // post-track sequencer states
   typedef enum logic [1:0] {
      PT_IDLE,
      PT_SYS,
      PT_SAR,
      PT_DONE
   } adwd_pt_state_e;
   // two-bit post-track select code
   typedef logic [1:0] adwd_pts_t;
endpackage

// *** adwd_post_track.sv ***
// post-track timer: two system clock cycles then 2..16 SAR clock ticks
// assumes sar_tick_i is a one-cycle pulse per SAR clock period
`timescale 1ns/1ps
`include "adwd_params.svh"
module adwd_post_track (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // control
   input wire adwd_pkg::adwd_pts_t pts_i,
   input wire logic start_i,
   input wire logic sar_tick_i,
   // status
   output logic busy_o,
   output logic done_o
);
   adwd_pkg::adwd_pt_state_e state_r; // sequencer state
   logic [4:0] cnt_r; // cycles or ticks still to go
   logic [4:0] sar_target; // ticks for the chosen code

   // code n gives 2 << n SAR ticks
   assign sar_target = `ADWD_SAR_BASE << pts_i;

   // ------------------------------------------------------------
   // sequencer: system cycles first, then SAR ticks
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_r <= adwd_pkg::PT_IDLE;
         cnt_r <= `ADWD_CNT_ZERO;
      end else begin
         case (state_r)
            adwd_pkg::PT_IDLE: begin
               // a start while busy is ignored
               if (start_i) begin
                  state_r <= adwd_pkg::PT_SYS;
                  cnt_r <= `ADWD_SYS_CYCLES;
               end
            end
            adwd_pkg::PT_SYS: begin
               if (cnt_r == `ADWD_CNT_ONE) begin
                  state_r <= adwd_pkg::PT_SAR;
                  cnt_r <= sar_target;
               end else begin
                  cnt_r <= cnt_r - `ADWD_CNT_ONE;
               end
            end
            adwd_pkg::PT_SAR: begin
               // code was sampled on entry to this state; a change now does not alter the count
               if (sar_tick_i) begin
                  if (cnt_r == `ADWD_CNT_ONE) begin
                     state_r <= adwd_pkg::PT_DONE;
                  end
                  cnt_r <= cnt_r - `ADWD_CNT_ONE;
               end
            end
            default: begin
               state_r <= adwd_pkg::PT_IDLE;
            end
         endcase
      end
   end

   // handshake outputs straight from the state
   assign busy_o = (state_r != adwd_pkg::PT_IDLE);
   assign done_o = (state_r == adwd_pkg::PT_DONE);

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic [4:0] ticks_r; // helper: SAR ticks seen in this window
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || state_r == adwd_pkg::PT_IDLE) begin
         ticks_r <= `ADWD_CNT_ZERO;
      end else if (state_r == adwd_pkg::PT_SAR && sar_tick_i) begin
         ticks_r <= ticks_r + `ADWD_CNT_ONE;
      end
   end

   sequence s_start;
      start_i && state_r == adwd_pkg::PT_IDLE;
   endsequence
   sequence s_sys_phase;
      (state_r == adwd_pkg::PT_SYS) [*2] ##1 (state_r == adwd_pkg::PT_SAR);
   endsequence

   chk_sys_phase: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      s_start |=> s_sys_phase)
      else $error("post-track system cycle phase is not two cycles");
   chk_sar_ticks: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      $rose(done_o) |-> ticks_r == (`ADWD_SAR_BASE << pts_i))
      else $error("post-track SAR tick count is wrong");
endmodule

// *** adwd_window_detector.sv ***
// converter window detector with limit registers and post-track timer
// assumes result and done pulse come from the converter on sys_clk_i
`timescale 1ns/1ps
`include "adwd_params.svh"
module adwd_window_detector (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // special function register bus
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_page_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_wdata_i,
   output logic [7:0] sfr_rdata_o,
   // converter result, already in its selected justification
   input wire logic conv_done_i,
   input wire logic [15:0] result_i,
   // post-track timing
   input wire logic track_start_i,
   input wire logic sar_tick_i,
   output logic post_track_busy_o,
   output logic post_track_done_o,
   // window flag to the interrupt controller
   output logic window_irq_o
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0] greater_than_limit_high_r; // greater-than word high
   logic [7:0] greater_than_limit_low_r; // greater-than word low
   logic [7:0] less_than_limit_high_r; // less-than word high
   logic [7:0] less_than_limit_low_r; // less-than word low
   logic [7:0] converter_control_reg_r; // control, flag bit is hardware
   logic [7:0] track_reg_r; // holds post_track_select
   logic window_compare_flag_r; // sticky window hit
   logic [7:0] rdata_r; // registered read data
   logic [15:0] gt_word; // assembled limits
   logic [15:0] lt_word;
   logic sel; // page 0 selected
   logic hit; // current result meets the condition
   logic flag_nxt;
   logic ctrl_wr;

   assign sel = (sfr_page_i == `ADWD_PAGE);
   assign ctrl_wr = sfr_wr_i && sel && (sfr_addr_i == `ADWD_CTRL_ADDR);
   assign gt_word = {greater_than_limit_high_r, greater_than_limit_low_r};
   assign lt_word = {less_than_limit_high_r, less_than_limit_low_r};

   // ------------------------------------------------------------
   // limit registers, one write strobe per byte
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         greater_than_limit_high_r <= `ADWD_GT_RST;
         greater_than_limit_low_r <= `ADWD_GT_RST;
         less_than_limit_high_r <= `ADWD_LT_RST;
         less_than_limit_low_r <= `ADWD_LT_RST;
      end else if (sfr_wr_i && sel) begin
         // each byte is written alone; a result between two byte
         // writes sees a half-updated limit, so software pauses it
         if (sfr_addr_i == `ADWD_GTH_ADDR) begin
            greater_than_limit_high_r <= sfr_wdata_i;
         end else if (sfr_addr_i == `ADWD_GTL_ADDR) begin
            greater_than_limit_low_r <= sfr_wdata_i;
         end else if (sfr_addr_i == `ADWD_LTH_ADDR) begin
            less_than_limit_high_r <= sfr_wdata_i;
         end else if (sfr_addr_i == `ADWD_LTL_ADDR) begin
            less_than_limit_low_r <= sfr_wdata_i;
         end
      end
   end

   // ------------------------------------------------------------
   // control and post-track select registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         converter_control_reg_r <= `ADWD_CTRL_RST;
         track_reg_r <= `ADWD_TRACK_RST;
      end else if (sfr_wr_i && sel) begin
         if (sfr_addr_i == `ADWD_CTRL_ADDR) begin
            converter_control_reg_r <= sfr_wdata_i;
         end else if (sfr_addr_i == `ADWD_TRACK_ADDR) begin
            track_reg_r <= sfr_wdata_i;
         end
      end
   end

   // ------------------------------------------------------------
   // window comparison
   // ------------------------------------------------------------
   // limit order alone decides the mode; no mode bit exists
   // the raw 16-bit word is compared, so justification must match
   always_comb begin
      if (lt_word > gt_word) begin
         hit = (result_i > gt_word) && (result_i < lt_word);
      end else begin
         hit = (result_i < gt_word) || (result_i > lt_word);
      end
   end

   // set by a hit wins over a clearing write in the same cycle
   always_comb begin
      flag_nxt = window_compare_flag_r;
      if (ctrl_wr) begin
         flag_nxt = sfr_wdata_i[`ADWD_FLAG_BIT];
      end
      if (conv_done_i && hit) begin
         flag_nxt = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         window_compare_flag_r <= 1'b0;
      end else begin
         window_compare_flag_r <= flag_nxt;
      end
   end

   // level request; the interrupt controller masks it
   assign window_irq_o = window_compare_flag_r;

   // ------------------------------------------------------------
   // read path, answered one cycle after the strobe
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rdata_r <= `ADWD_ZERO8;
      end else if (sfr_rd_i && sel) begin
         if (sfr_addr_i == `ADWD_GTH_ADDR) begin
            rdata_r <= greater_than_limit_high_r;
         end else if (sfr_addr_i == `ADWD_GTL_ADDR) begin
            rdata_r <= greater_than_limit_low_r;
         end else if (sfr_addr_i == `ADWD_LTH_ADDR) begin
            rdata_r <= less_than_limit_high_r;
         end else if (sfr_addr_i == `ADWD_LTL_ADDR) begin
            rdata_r <= less_than_limit_low_r;
         end else if (sfr_addr_i == `ADWD_CTRL_ADDR) begin
            rdata_r <= converter_control_reg_r;
            rdata_r[`ADWD_FLAG_BIT] <= window_compare_flag_r;
         end else if (sfr_addr_i == `ADWD_TRACK_ADDR) begin
            rdata_r <= track_reg_r;
         end else begin
            rdata_r <= `ADWD_ZERO8; // unmapped reads as zero
         end
      end
   end

   assign sfr_rdata_o = rdata_r;

   // ------------------------------------------------------------
   // post-track timer
   // ------------------------------------------------------------
   adwd_post_track u_post_track (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .pts_i(track_reg_r[`ADWD_PTS_HI:`ADWD_PTS_LO]),
      .start_i(track_start_i),
      .sar_tick_i(sar_tick_i),
      .busy_o(post_track_busy_o),
      .done_o(post_track_done_o)
   );

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   chk_gt_high_reset: assert property (@(posedge sys_clk_i)
      $past(rst_i) && rst_i |-> gt_word == 16'hffff)
      else $error("greater-than limit not all ones in reset");
   chk_lt_reset: assert property (@(posedge sys_clk_i)
      $past(rst_i) && rst_i |-> lt_word == 16'h0000)
      else $error("less-than limit not zero in reset");
   chk_gt_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      sfr_wr_i && sel && sfr_addr_i == `ADWD_GTH_ADDR
      |=> greater_than_limit_high_r == $past(sfr_wdata_i))
      else $error("greater-than high byte did not take write");
   chk_inside_hit: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      conv_done_i && lt_word > gt_word && result_i > gt_word
      && result_i < lt_word |=> window_compare_flag_r)
      else $error("inside-window result did not set flag");
   chk_outside_hit: assert property (@(posedge sys_clk_i)
      disable iff (rst_i)
      conv_done_i && !(lt_word > gt_word)
      && (result_i < gt_word || result_i > lt_word)
      |=> window_compare_flag_r)
      else $error("outside-window result did not set flag");
   chk_no_false_set: assert property (@(posedge sys_clk_i)
      disable iff (rst_i)
      !window_compare_flag_r && !ctrl_wr && !(conv_done_i && hit)
      |=> !window_compare_flag_r)
      else $error("flag set without a hit");
   chk_flag_sticky: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      window_compare_flag_r && !ctrl_wr |=> window_compare_flag_r [*1]
      )
      else $error("flag dropped without a clearing write");
   chk_flag_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ctrl_wr && !sfr_wdata_i[`ADWD_FLAG_BIT] && !(conv_done_i && hit)
      |=> !window_compare_flag_r)
      else $error("writing zero did not clear flag");
   chk_flag_poll: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      sfr_rd_i && sel && sfr_addr_i == `ADWD_CTRL_ADDR
      |=> sfr_rdata_o[`ADWD_FLAG_BIT] == $past(window_compare_flag_r)
      && window_irq_o == window_compare_flag_r)
      else $error("polled flag differs from flag state");
endmodule

// *** tb_adwd_window_detector.sv ***
// self-checking bench for the converter window detector and post-track timer
// assumes the design files and adwd_params.svh are compiled alongside
`timescale 1ns/1ps
`include "adwd_params.svh"
module tb_adwd_window_detector;
   // ------------------------------------------------------------
   // design signals
   // ------------------------------------------------------------
   logic sys_clk_i, rst_i, sfr_wr_i, sfr_rd_i, conv_done_i;
   logic track_start_i, sar_tick_i;
   logic [7:0] sfr_addr_i, sfr_page_i, sfr_wdata_i, sfr_rdata_o;
   logic [15:0] result_i;
   logic post_track_busy_o, post_track_done_o, window_irq_o;
   // bench bookkeeping and reference model state
   int fails, tests_run;
   logic [15:0] gt_m, lt_m; // model limit words
   logic flag_m; // model window flag
   logic [7:0] rd_v; // last value read back
   logic [7:0] addr_tab [6] = '{8'hc4, 8'hc3, 8'hc6, 8'hc5, 8'hc0, 8'hc1};
   logic [7:0] rst_tab [6] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};

   adwd_window_detector dut (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .sfr_addr_i(sfr_addr_i), .sfr_page_i(sfr_page_i),
      .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
      .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
      .conv_done_i(conv_done_i), .result_i(result_i),
      .track_start_i(track_start_i), .sar_tick_i(sar_tick_i),
      .post_track_busy_o(post_track_busy_o),
      .post_track_done_o(post_track_done_o),
      .window_irq_o(window_irq_o)
   );

   // ------------------------------------------------------------
   // clock: 100 ns period
   // ------------------------------------------------------------
   initial begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   // one comparison; x or z on the design side never matches
   task check(string what, logic [15:0] exp, logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask

   // bus write; model follows only writes that select page 0
   task sfr_write(logic [7:0] page, logic [7:0] addr, logic [7:0] data);
      @(posedge sys_clk_i);
      sfr_page_i <= page;
      sfr_addr_i <= addr;
      sfr_wdata_i <= data;
      sfr_wr_i <= 1'b1;
      @(posedge sys_clk_i);
      sfr_wr_i <= 1'b0;
      if (page == 8'h00) begin
         case (addr)
            `ADWD_GTH_ADDR: gt_m[15:8] = data;
            `ADWD_GTL_ADDR: gt_m[7:0] = data;
            `ADWD_LTH_ADDR: lt_m[15:8] = data;
            `ADWD_LTL_ADDR: lt_m[7:0] = data;
            `ADWD_CTRL_ADDR: flag_m = data[`ADWD_FLAG_BIT];
            default: ;
         endcase
      end
   endtask

   // bus read; data is registered, so it is taken just after the edge
   task sfr_read(logic [7:0] page, logic [7:0] addr);
      @(posedge sys_clk_i);
      sfr_page_i <= page;
      sfr_addr_i <= addr;
      sfr_rd_i <= 1'b1;
      @(posedge sys_clk_i);
      sfr_rd_i <= 1'b0;
      #1 rd_v = sfr_rdata_o;
   endtask

   // one conversion; the model decides inside or outside by limit order
   task conv(logic [15:0] res);
      logic hit;
      @(posedge sys_clk_i);
      conv_done_i <= 1'b1;
      result_i <= res;
      @(posedge sys_clk_i);
      conv_done_i <= 1'b0;
      if (lt_m > gt_m)
         hit = (res > gt_m) && (res < lt_m);
      else
         hit = (res < gt_m) || (res > lt_m);
      flag_m = flag_m | hit;
      #1 check("window flag", {15'h0, flag_m}, {15'h0, window_irq_o});
   endtask

   // post-track run: ticks on even cycles, those before cycle 3 ignored
   task track(logic [1:0] code, logic extra);
      int k, n;
      n = 2 << code;
      sfr_write(8'h00, `ADWD_TRACK_ADDR, {6'h0, code});
      @(posedge sys_clk_i);
      track_start_i <= 1'b1;
      sar_tick_i <= 1'b1;
      for (k = 1; k <= 4 + 2 * n; k++) begin
         @(posedge sys_clk_i);
         track_start_i <= extra && (k == 5);
         sar_tick_i <= (k % 2 == 0);
         #1;
         check("post-track done", {15'h0, k == 3 + 2 * n},
            {15'h0, post_track_done_o});
         check("post-track busy", {15'h0, k <= 3 + 2 * n},
            {15'h0, post_track_busy_o});
      end
      @(posedge sys_clk_i);
      sar_tick_i <= 1'b0;
   endtask

   // closing report and verdict
   task print_verdict;
      $display("tests_run=%0d fails=%0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // watchdog: the whole run needs about 510 cycles
   // ------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      fails++;
      print_verdict;
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      logic [15:0] res;
      logic [7:0] w; // random byte written to a limit
      int i, sel;
      fails = 0;
      tests_run = 0;
      rst_i = 1'b1;
      sfr_wr_i = 1'b0;
      sfr_rd_i = 1'b0;
      sfr_addr_i = 8'h00;
      sfr_page_i = 8'h00;
      sfr_wdata_i = 8'h00;
      conv_done_i = 1'b0;
      result_i = 16'h0000;
      track_start_i = 1'b0;
      sar_tick_i = 1'b0;
      gt_m = 16'hffff;
      lt_m = 16'h0000;
      flag_m = 1'b0;
      void'($urandom(32'hd874));
      repeat (6) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      // reset values of every mapped register
      for (i = 0; i < 6; i++) begin
         sfr_read(8'h00, addr_tab[i]);
         check("reset value", {8'h0, rst_tab[i]}, {8'h0, rd_v});
      end
      // unmapped address reads zero
      sfr_read(8'h00, 8'h10);
      check("unmapped read", 16'h0000, {8'h0, rd_v});
      // a write on another page leaves the limit untouched
      sfr_write(8'h01, `ADWD_GTH_ADDR, 8'h00);
      sfr_read(8'h00, `ADWD_GTH_ADDR);
      check("other page write", 16'h00ff, {8'h0, rd_v});
      sfr_read(8'h01, `ADWD_LTH_ADDR);
      check("other page read", 16'h00ff, {8'h0, rd_v});
      // each limit byte is writable on its own and reads back
      for (i = 0; i < 4; i++) begin
         w = 8'($urandom);
         sfr_write(8'h00, addr_tab[i], w);
         sfr_read(8'h00, addr_tab[i]);
         check("limit byte", {8'h0, w}, {8'h0, rd_v});
      end
      // random windows, both orders, results on and next to the limits
      for (i = 0; i < 60; i++) begin
         if (i % 5 == 0) begin
            sfr_write(8'h00, `ADWD_CTRL_ADDR, 8'h00);
            sfr_write(8'h00, `ADWD_GTH_ADDR, 8'($urandom));
            sfr_write(8'h00, `ADWD_GTL_ADDR, 8'($urandom));
            sfr_write(8'h00, `ADWD_LTH_ADDR, 8'($urandom));
            sfr_write(8'h00, `ADWD_LTL_ADDR, 8'($urandom));
         end
         sel = $urandom % 6;
         case (sel)
            0: res = gt_m;
            1: res = lt_m;
            2: res = gt_m + 16'h0001;
            3: res = lt_m - 16'h0001;
            4: res = gt_m - 16'h0001;
            default: res = 16'($urandom);
         endcase
         conv(res);
         sfr_read(8'h00, `ADWD_CTRL_ADDR);
         check("control flag", {12'h0, flag_m, 3'h0}, {8'h0, rd_v});
      end
      // writing zero clears a set flag
      sfr_write(8'h00, `ADWD_CTRL_ADDR, 8'h08);
      #1 check("flag set", 16'h0001, {15'h0, window_irq_o});
      sfr_write(8'h00, `ADWD_CTRL_ADDR, 8'h00);
      #1 check("flag clear", 16'h0000, {15'h0, window_irq_o});
      // a hit in the cycle of a clearing write wins over the clear
      sfr_write(8'h00, `ADWD_GTH_ADDR, 8'hff);
      sfr_write(8'h00, `ADWD_GTL_ADDR, 8'hff);
      sfr_write(8'h00, `ADWD_LTH_ADDR, 8'h00);
      sfr_write(8'h00, `ADWD_LTL_ADDR, 8'h00);
      @(posedge sys_clk_i);
      sfr_addr_i <= `ADWD_CTRL_ADDR;
      sfr_wdata_i <= 8'h00;
      sfr_wr_i <= 1'b1;
      conv_done_i <= 1'b1;
      result_i <= 16'h0001;
      @(posedge sys_clk_i);
      sfr_wr_i <= 1'b0;
      conv_done_i <= 1'b0;
      #1 check("set over clear", 16'h0001, {15'h0, window_irq_o});
      flag_m = 1'b1;
      // every post-track code, a stray start while busy on two of them
      for (i = 0; i < 4; i++) begin
         track(2'(i), i[0]);
      end
      print_verdict;
   end
endmodule
